//--- src/pbs_pkg.sv
// Constants shared by the pipelined burst memory port.
// Assumes a single hclk domain and an AHB-Lite register bus.
`default_nettype none

package pbs_pkg;

  // ------------------------------------------------------------
  // Organisations
  // ------------------------------------------------------------
  localparam int LANE_W     = 9;
  localparam int ORG_A_ADDR = 18;
  localparam int ORG_A_DATA = 36;
  localparam int ORG_B_ADDR = 19;
  localparam int ORG_B_DATA = 18;
  localparam int BURST_W    = 2;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int          OFF_W        = 8;
  localparam logic [7:0]  REG_CTRL_OFF = 8'h00;
  localparam logic [7:0]  REG_STAT_OFF = 8'h04;
  localparam int          CTRL_W       = 2;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;
  localparam int          CTRL_ILV_BIT = 0;
  localparam int          CTRL_SLP_BIT = 1;
  localparam int          STAT_SLP_BIT = 0;
  localparam int          STAT_DRV_BIT = 1;
  localparam int          STAT_WPD_BIT = 2;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;

endpackage

`default_nettype wire

//--- src/pbs_sram_port.sv
// Pipelined burst static memory with its synchronous host port.
// Assumes the host drives all pins from hclk and that the
// testbench resolves the data wire from dq_oe_n.
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`default_nettype none

module pbs_sram_port
  import pbs_pkg::*;
#(
  parameter int ADDR_W = ORG_A_ADDR,
  parameter int DATA_W = ORG_A_DATA,
  localparam int LANES = DATA_W / LANE_W
) (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite register slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Memory command pins
  input  wire logic [ADDR_W-1:0] sram_addr,
  input  wire logic              chip_select_1_n,
  input  wire logic              chip_select_2,
  input  wire logic              chip_select_3_n,
  input  wire logic              write_n,
  input  wire logic              advance_or_load,
  input  wire logic              clock_qualify_n,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  input  wire logic              output_enable_n,
  // Data pins, parity bits top of each lane
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n
);

  // ------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------
  localparam int MAX_A = (LANES == 4) ? ORG_A_ADDR : ORG_B_ADDR;

  if (DATA_W % LANE_W != 0 || !(LANES == 2 || LANES == 4) ||
      ADDR_W < BURST_W + 1 || ADDR_W > MAX_A) begin : g_bad_cfg
    $error("pbs_sram_port: unsupported organisation");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Low address bits of a burst beat.
  function automatic logic [BURST_W-1:0] burst_lo(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] cnt,
    input logic               ilv
  );
    burst_lo = ilv ? (start ^ cnt) : (start + cnt);
  endfunction

  // Byte-lane merge of new data over old data.
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [LANES-1:0]  mask
  );
    merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) begin
        merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [DATA_W-1:0]  mem_q [2**ADDR_W];
  logic [CTRL_W-1:0]  ctrl_q;
  logic               v1_q, wr1_q, v2_q, wr2_q;
  logic [ADDR_W-1:0]  base1_q, a2_q, wa_q, wca_q;
  logic [BURST_W-1:0] start1_q, cnt1_q;
  logic               wv_q, wc_q, drive_q;
  logic [DATA_W-1:0]  wd_q, dout_q;
  logic [LANES-1:0]   we_q;
  logic               aw_q;
  logic [OFF_W-1:0]   aa_q;
  logic [31:0]        hrdata_q;
  logic               hready_q, hresp_q;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire en       = ~clock_qualify_n;
  wire sleeping = ctrl_q[CTRL_SLP_BIT];
  wire ilv      = ctrl_q[CTRL_ILV_BIT];
  wire sel      = ~chip_select_1_n & chip_select_2 & ~chip_select_3_n;
  wire load     = ~advance_or_load;

  wire [ADDR_W-1:0] addr1 =
    {base1_q[ADDR_W-1:BURST_W], burst_lo(start1_q, cnt1_q, ilv)};

  // A burst continues the previous operation; sleep deselects.
  wire               v1_d     = ~sleeping & (load ? sel : v1_q);
  wire               wr1_d    = load ? ~write_n : wr1_q;
  wire [ADDR_W-1:0]  base1_d  = load ? sram_addr : base1_q;
  wire [BURST_W-1:0] start1_d = load ? sram_addr[BURST_W-1:0] : start1_q;
  wire [BURST_W-1:0] cnt1_d   = load ? '0 : cnt1_q + 2'h1;

  // Write data comes one cycle after edge n+2, in the same slot that
  // read data uses, so reads and writes share the bus without gaps.
  // Two writes may still be short of the array when a read looks:
  // one held in the data register, and one whose data is on the pins
  // right now. The newer one is merged last so that it wins.
  wire               fwd_hit  = wc_q & (wca_q == a2_q);
  wire               fwd_new  = wv_q & (wa_q == a2_q);
  wire [LANES-1:0]   fwd_mask = fwd_hit ? we_q : '0;
  wire [LANES-1:0]   new_mask = fwd_new ? ~byte_lane_write_n : '0;
  wire [DATA_W-1:0]  old_word = merge(mem_q[a2_q], wd_q, fwd_mask);
  wire [DATA_W-1:0]  rd_word  = merge(old_word, dq_in, new_mask);
  wire               rd_beat  = v2_q & ~wr2_q & ~sleeping;
  wire               wr_beat  = v2_q & wr2_q;

  // ------------------------------------------------------------
  // Input and pipeline registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      v1_q     <= 1'b0;
      wr1_q    <= 1'b0;
      base1_q  <= '0;
      start1_q <= '0;
      cnt1_q   <= '0;
      v2_q     <= 1'b0;
      wr2_q    <= 1'b0;
      a2_q     <= '0;
    end else if (en) begin
      v1_q     <= v1_d;
      wr1_q    <= wr1_d;
      base1_q  <= base1_d;
      start1_q <= start1_d;
      cnt1_q   <= cnt1_d;
      v2_q     <= v1_q;
      wr2_q    <= wr1_q;
      a2_q     <= addr1;
    end
  end

  // ------------------------------------------------------------
  // Output and write data registers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout_q  <= '0;
      drive_q <= 1'b0;
      wv_q    <= 1'b0;
      wa_q    <= '0;
      wc_q    <= 1'b0;
      wca_q   <= '0;
      wd_q    <= '0;
      we_q    <= '0;
    end else if (en) begin
      dout_q  <= rd_beat ? rd_word : dout_q;
      drive_q <= rd_beat;
      wv_q    <= wr_beat;
      wa_q    <= a2_q;
      wc_q    <= wv_q;
      wca_q   <= wa_q;
      wd_q    <= dq_in;
      we_q    <= ~byte_lane_write_n;
    end
  end

  // Array write one qualified edge after the data is held.
  always_ff @(posedge hclk) begin
    if (en && wc_q) begin
      mem_q[wca_q] <= merge(mem_q[wca_q], wd_q, we_q);
    end
  end

  assign dq_out  = dout_q;
  assign dq_oe_n = ~drive_q | output_enable_n;

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  wire              accept = hsel & hready & htrans[1];
  wire [OFF_W-1:0]  aoff   = haddr[OFF_W-1:0];
  wire [31:0]       ctrl_word = {{(32 - CTRL_W){1'b0}}, ctrl_q};
  logic [31:0]      stat_word;

  always_comb begin
    stat_word = '0;
    stat_word[STAT_SLP_BIT] = sleeping;
    stat_word[STAT_DRV_BIT] = drive_q;
    stat_word[STAT_WPD_BIT] = wv_q | wc_q;
  end

  wire [31:0] rd_mux = (aoff == REG_CTRL_OFF) ? ctrl_word :
                       (aoff == REG_STAT_OFF) ? stat_word : '0;
  wire ctrl_wr = aw_q & (aa_q == REG_CTRL_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_q     <= 1'b0;
      aa_q     <= '0;
      hrdata_q <= '0;
      ctrl_q   <= CTRL_RESET;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end else begin
      aw_q     <= accept & hwrite & (hsize == HSIZE_WORD);
      aa_q     <= accept ? aoff : aa_q;
      hrdata_q <= (accept && !hwrite) ? rd_mux : '0;
      ctrl_q   <= ctrl_wr ? hwdata[CTRL_W-1:0] : ctrl_q;
      hready_q <= 1'b1;
      hresp_q  <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = hresp_q;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_load_capture: assert property (
    (en && load && sel && !sleeping) |=>
      v1_q && base1_q == $past(sram_addr) && wr1_q == !$past(write_n))
    else $error("load command not captured");

  a_deselect: assert property (
    (en && load && !sel) |=> !v1_q)
    else $error("deselected command accepted");

  a_read_pipe: assert property (
    (en && v1_q && !wr1_q && !sleeping) ##1
      (en && !sleeping)[*1] |=> drive_q)
    else $error("read data not driven after n+2");

  a_write_hiz: assert property (
    (en && wr_beat) |=> !drive_q ##0 wv_q && wa_q == $past(a2_q))
    else $error("driving during write data");

  a_suspend_hold: assert property (
    !en |=> $stable(dout_q) && $stable(drive_q) && $stable(v2_q)
      && $stable(addr1) && $stable(wv_q) && $stable(wc_q))
    else $error("pipeline moved while suspended");

  a_no_bubble: assert property (
    (en && v1_q) |=> v2_q && a2_q == $past(addr1))
    else $error("pipeline inserted a bubble");

  a_burst_step: assert property (
    (en && !load && v1_q && !sleeping) |=>
      v1_q && wr1_q == $past(wr1_q) &&
      cnt1_q == $past(cnt1_q) + 2'h1)
    else $error("burst did not advance");

  a_oe_async: assert property (
    output_enable_n |-> dq_oe_n)
    else $error("driving with output enable high");

  a_sleep_block: assert property (
    (en && sleeping) |=> !v1_q ##1 (en && !$past(v2_q))[*1]
      |-> !v2_q)
    else $error("access accepted while asleep");

  a_fwd_read: assert property (
    (en && rd_beat && fwd_hit && !fwd_new && we_q == '1) |=>
      dout_q == $past(wd_q))
    else $error("read missed pending write");

  a_fwd_pins: assert property (
    (en && rd_beat && fwd_new && byte_lane_write_n == '0) |=>
      dout_q == $past(dq_in))
    else $error("read missed write data on the pins");

  a_write_capture: assert property (
    (en && wv_q) |=> wc_q && wca_q == $past(wa_q) &&
      we_q == ~$past(byte_lane_write_n))
    else $error("write data not captured");

  c_read: cover property (en && rd_beat);
  c_write: cover property (en && wr_beat);
  c_turn: cover property (en && rd_beat ##1 en && wr_beat);
  c_suspend: cover property (v2_q && !en ##1 en);

endmodule

`default_nettype wire

//--- bench/pbs_host_model.sv
// Host memory controller model driving the burst port's pins.
// Assumes issue is called once per cycle just after hclk rises.
`default_nettype none
module pbs_host_model
  import pbs_pkg::*;
#(
  parameter int AW = 4,
  parameter int LN = 4
) (
  // Clock
  input  wire logic             hclk,
  input  wire logic             clock_qualify_n,
  // Command and data pins
  output logic [AW-1:0]         sram_addr,
  output logic [2:0]            cs,
  output logic                  write_n,
  output logic                  advance_or_load,
  output logic [LN-1:0]         byte_lane_write_n,
  output logic [LANE_W*LN-1:0]  dq_host
);
  timeunit 1ns;
  timeprecision 1ns;
  logic                  wr_q;
  logic [3:0]            wv_q;
  logic [LANE_W*LN-1:0]  wd_q [4];
  logic [LN-1:0]         wl_q [4];

  initial begin
    wr_q = 1'b0;
    wv_q = 4'h0;
    wd_q = '{default: '0};
  end

  task automatic issue(input logic ld, input logic wr, input logic [2:0] c,
                       input logic [AW-1:0] a,
                       input logic [LANE_W*LN-1:0] d,
                       input logic [LN-1:0] ln);
    if (ld)
      wr_q = wr && c == 3'h2;
    sram_addr <= ld ? a : ~a;
    cs <= c;
    write_n <= !wr;
    advance_or_load <= !ld;
    wv_q[0] <= wr_q;
    wd_q[0] <= d;
    wl_q[0] <= ln;
  endtask

  // ------------------------------------------------------------
  // Write data pipeline
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    if (!clock_qualify_n) begin
      wv_q[3:1] <= wv_q[2:0];
      wd_q[1] <= wd_q[0];
      wd_q[2] <= wd_q[1];
      wd_q[3] <= wd_q[2];
      wl_q[1] <= wl_q[0];
      wl_q[2] <= wl_q[1];
      wl_q[3] <= wl_q[2];
    end
  end

  // A released bus shows the inverse word, never a held value.
  assign dq_host = wv_q[3] ? wd_q[3] : ~wd_q[3];
  assign byte_lane_write_n = wv_q[3] ? ~wl_q[3] : '1;
endmodule
`default_nettype wire

//--- bench/pbs_sram_port_tb.sv
// Self-checking bench for the pipelined burst memory port.
// Assumes pbs_pkg and the host model are compiled first.
`default_nettype none
module pbs_sram_port_tb import pbs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 4;
  localparam int DW = 36;
  localparam int LN = 4;
  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic          hwrite = 1'b0;
  logic [1:0]    htrans = 2'h0;
  logic [2:0]    hsize = 3'h2;
  logic [31:0]   haddr = 32'h0;
  logic [31:0]   hwdata = 32'h0;
  logic [31:0]   hrdata;
  logic          hreadyout, hresp, dq_oe_n, write_n, advance_or_load;
  logic          clock_qualify_n = 1'b0;
  logic          output_enable_n = 1'b0;
  logic [2:0]    cs;
  logic [AW-1:0] sram_addr, bs;
  logic [LN-1:0] byte_lane_write_n;
  logic [DW-1:0] dq_host, dq_in, dq_out, ld_q;
  logic [DW-1:0] mem [16];
  logic [DW-1:0] qd [$];
  int            qt [$];
  int            failures = 0;
  int            total_checks = 0;
  int            cyc = 0;
  logic          opv = 0, opw = 0, ilv = 0, slp = 0, hold = 0;
  logic          lv = 0;
  logic [1:0]    bc;

  always #25 hclk = ~hclk;
  assign dq_in = dq_oe_n ? dq_host : dq_out;

  pbs_sram_port #(.ADDR_W(AW), .DATA_W(DW)) pbs_sram_port_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
    .sram_addr, .chip_select_1_n(cs[2]), .chip_select_2(cs[1]),
    .chip_select_3_n(cs[0]), .write_n, .advance_or_load,
    .clock_qualify_n, .byte_lane_write_n, .output_enable_n,
    .dq_in, .dq_out, .dq_oe_n);
  pbs_host_model #(.AW(AW), .LN(LN)) pbs_host_model_i (
    .hclk, .clock_qualify_n, .sram_addr, .cs, .write_n,
    .advance_or_load, .byte_lane_write_n, .dq_host);

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [DW-1:0] e,
                     input logic [DW-1:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, HSIZE_WORD);
    chk("register", DW'(e), DW'(hrdata));
    chk("hresp", DW'(1'b0), DW'(hresp));
  endtask

  function automatic logic [AW-1:0] beat_addr(input logic [AW-1:0] b,
                                               input logic [1:0]    c,
                                               input logic          il);
    beat_addr = {b[AW-1:2], il ? b[1:0] ^ c : b[1:0] + c};
  endfunction

  // One bus cycle; read expectations fall due three steps later.
  task automatic step(input logic ld, input logic wr, input logic [2:0] c,
                      input logic [AW-1:0] a, input logic [LN-1:0] ln,
                      input logic fz);
    logic [DW-1:0] d;
    logic [AW-1:0] ea;
    d = DW'({$urandom, $urandom});
    @(posedge hclk);
    clock_qualify_n <= fz;
    output_enable_n <= ($urandom % 8 == 0);
    if (!fz) begin
      pbs_host_model_i.issue(ld, wr, c, a, d, ln);
      if (ld) begin
        opv = c == 3'h2 && !slp;
        opw = wr;
        bs = a;
        bc = 2'h0;
      end else
        bc = bc + 2'h1;
      ea = beat_addr(bs, bc, ilv);
      for (int k = 0; k < LN; k++)
        if (opv && opw && ln[k])
          mem[ea][9*k +: 9] = d[9*k +: 9];
      if (opv && !opw) begin
        qt.push_back(cyc + 4);
        qd.push_back(mem[ea]);
      end
    end
    @(negedge hclk);
    cyc++;
    if (!hold) begin
      lv = qt.size() > 0 && qt[0] == cyc;
      if (lv) begin
        void'(qt.pop_front());
        ld_q = qd.pop_front();
      end
    end
    chk("dq_oe_n", DW'(!lv || output_enable_n), DW'(dq_oe_n));
    if (lv) chk("dq_out", ld_q, dq_out);
    hold = fz;
    if (fz) foreach (qt[i]) qt[i]++;
  endtask

  // Random mix of loads, burst beats and suspended edges, then a drain.
  task automatic mix(input int n);
    int r;
    for (int i = 0; i < n; i++) begin
      r = $urandom % 16;
      if (r < 2)
        step(1'b0, 1'b0, 3'h0, '0, '0, 1'b1);
      else if (r < 4)
        step(1'b1, 1'b0, 3'($urandom), AW'($urandom), '0, 1'b0);
      else if (r < 9 && opv)
        step(1'b0, opw, 3'h2, AW'($urandom), LN'($urandom), 1'b0);
      else
        step(1'b1, 1'($urandom), 3'h2, AW'($urandom),
             LN'($urandom), 1'b0);
    end
    repeat (6) step(1'b1, 1'b0, 3'h0, '0, '0, 1'b0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    pbs_host_model_i.issue(1'b1, 1'b0, 3'h0, '0, '0, '0);
    void'($urandom(78526));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(REG_CTRL_OFF, 32'h0);
    rchk(REG_STAT_OFF, 32'h0);
    rchk(8'h08, 32'h0);
    ahb(1'b1, REG_CTRL_OFF, 32'h3, 3'h0);
    rchk(REG_CTRL_OFF, 32'h0);
    for (int i = 0; i < 16; i++)
      step(1'b1, 1'b1, 3'h2, AW'(i), '1, 1'b0);
    step(1'b1, 1'b1, 3'h2, AW'(5), '1, 1'b0);
    step(1'b1, 1'b0, 3'h2, AW'(5), '0, 1'b0);
    step(1'b1, 1'b1, 3'h2, AW'(6), '1, 1'b0);
    step(1'b1, 1'b0, 3'h2, AW'(6), '0, 1'b0);
    step(1'b1, 1'b1, 3'h2, AW'(7), '1, 1'b0);
    step(1'b1, 1'b0, 3'h2, AW'(8), '0, 1'b0);
    step(1'b1, 1'b0, 3'h2, AW'(7), '0, 1'b0);
    mix(400);
    ahb(1'b1, REG_CTRL_OFF, 32'h1, HSIZE_WORD);
    ilv = 1'b1;
    mix(400);
    ahb(1'b1, REG_CTRL_OFF, 32'h3, HSIZE_WORD);
    slp = 1'b1;
    rchk(REG_STAT_OFF, 32'h1);
    mix(60);
    ahb(1'b1, REG_CTRL_OFF, 32'h0, HSIZE_WORD);
    slp = 1'b0;
    ilv = 1'b0;
    mix(200);
    close_out();
  end

  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
